// [verilog/tsf_pkg.sv]
// Purpose: constants shared by the status flag register bank
// Assumes: 250 MHz clock, 8-bit register port
// Notes:   offsets are word indices on the plain register port
package tsf_pkg;
  // ==================================================================
  // register map
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_MASK    = 4'h1;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_NODE_ID = 4'h3;
  localparam logic [3:0] ADDR_IRQ     = 4'h4;
  // ==================================================================
  // status bit positions
  localparam int BIT_RI   = 7;
  localparam int BIT_POR  = 4;
  localparam int BIT_TEST = 3;
  localparam int BIT_IDLE = 2;
  localparam int BIT_ACK  = 1;
  localparam int BIT_FREE = 0;
  localparam logic [7:0] STATUS_RESET = 8'h91;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] IRQ_BITS     = 8'h85;
  // ==================================================================
  // commands (low nibble is the opcode, bits 6:4 the page)
  // page kept clear of the opcode nibble so every page decodes
  localparam int         PAGE_LSB       = 4;
  localparam logic [3:0] CMD_DISABLE_TX = 4'h1;
  localparam logic [3:0] CMD_ENABLE_TX  = 4'h3;
  localparam logic [3:0] CMD_ENABLE_RX  = 4'h4;
  localparam logic [3:0] CMD_CLEAR_FLAG = 4'he;
  localparam logic [3:0] CMD_SOFT_RESET = 4'hf;
  // ==================================================================
  // timing
  localparam int CLOCK_MHZ     = 250;
  localparam int IDLE_TIME_NS10 = 205; // 20.5 us in units of 100 ns
  localparam int IDLE_CYCLES   = (IDLE_TIME_NS10 * CLOCK_MHZ) / 10;
  localparam int IDLE_W        = 13;
endpackage

// [verilog/tsf_idle_timer.sv]
// Purpose: line idle watchdog, pulses once after a quiet stretch
// Assumes: activity input synchronous to clock_i
// Notes:   restarts on every activity cycle
module tsf_idle_timer
  import tsf_pkg::*;
#(
  parameter int CYCLES = IDLE_CYCLES
) (
  input  wire logic clock_i,    // system clock
  input  wire logic rst_b_i,    // sync reset, low active
  input  wire logic active_i,   // line shows activity
  output logic      expired_o   // one-cycle expiry pulse
);
  logic [IDLE_W-1:0] count_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || active_i) begin
      count_reg <= '0;
      expired_o <= 1'b0;
    end else if (count_reg == IDLE_W'(CYCLES - 1)) begin
      // fires once, then counter parks until the line wakes
      count_reg <= IDLE_W'(CYCLES);
      expired_o <= 1'b1;
    end else begin
      if (count_reg != IDLE_W'(CYCLES)) begin
        count_reg <= count_reg + 1'b1;
      end
      expired_o <= 1'b0;
    end
  end
endmodule

// [verilog/tsf_status_flags.sv]
// Purpose: main status flags of a token-passing network controller
// Assumes: all inputs synchronous to clock_i; protocol engine supplies events
// Notes:   status register is read only; flags change by events and commands
//
// Contract
// (R1) receiver_inhibited high until enable-receive, set again when packet stored
// (R2) enable-receive-to-page command clears receiver_inhibited
// (R3) while receiver_inhibited, incoming packets are answered with a NAK
// (R4) interrupt when an enabled flag among ri, idle, tx_free is high
// (R5) status bits six and five undefined, host ignores them
// (R6) power_on_flag set by soft reset, hard reset, or node id write of zero
// (R7) power_on_flag cleared only by clear-flags command
// (R8) test bit reads zero in normal operation
// (R9) line_idle_timeout set when line quiet for 20.5 us
// (R10) clear-flags command clears line_idle_timeout
// (R11) host checks self_caused_idle_timeout when servicing idle timeout
// (R12) tx_acked set when the transmitted packet is acknowledged
// (R13) broadcast packets never set tx_acked
// (R14) host trusts tx_acked only after tx_free goes high
// (R15) enable-transmit command clears tx_acked
// (R16) tx_free set at last byte sent or on disable-transmitter
// (R17) after enable-transmit, tx_free clears when token next arrives
// (R18) eight-bit read-only status, reset value 1xx1 0001
// (R19) reading status alters no flag
module tsf_status_flags
  import tsf_pkg::*;
(
  input  wire logic       clock_i,          // system clock
  input  wire logic       rst_b_i,          // sync reset, low active
  input  wire logic [3:0] addr_i,           // register index
  input  wire logic [7:0] wdata_i,          // write data
  input  wire logic       wr_i,             // write strobe
  input  wire logic       rd_i,             // read strobe
  output logic      [7:0] rdata_o,          // read data, cycle after rd_i
  input  wire logic       line_receive_input, // receive line activity
  input  wire logic       rx_stored_i,      // packet stored into armed page
  input  wire logic       rx_request_i,     // another station offers a packet
  output logic            rx_nak_o,         // answer offer with NAK
  input  wire logic       tx_ack_i,         // destination acknowledged
  input  wire logic       tx_broadcast_i,   // current packet is broadcast
  input  wire logic       tx_done_i,        // last byte transmitted
  input  wire logic       token_i,          // node received the token
  output logic            tx_start_o,       // start scheduled transmission
  output logic      [2:0] tx_page_o,        // armed transmit page
  output logic      [2:0] rx_page_o,        // armed receive page
  output logic            soft_reset_o,     // soft reset pulse
  output logic            irq_o             // level interrupt
);
  // ==================================================================
  // command decode
  logic       cmd_wr;
  logic       cmd_tx;
  logic       cmd_rx;
  logic       cmd_dis;
  logic       cmd_clr;
  logic       cmd_srst;
  logic       node_zero;
  logic       idle_pulse;
  logic       tx_pending_reg;
  logic       ri_reg;
  logic       por_reg;
  logic       idle_reg;
  logic       ack_reg;
  logic       free_reg;
  logic [7:0] mask_reg;
  logic [7:0] status;
  logic [7:0] rdata_next;

  assign cmd_wr    = wr_i && (addr_i == ADDR_COMMAND);
  assign cmd_tx    = cmd_wr && (wdata_i[3:0] == CMD_ENABLE_TX);
  assign cmd_rx    = cmd_wr && (wdata_i[3:0] == CMD_ENABLE_RX);
  assign cmd_dis   = cmd_wr && (wdata_i[3:0] == CMD_DISABLE_TX);
  assign cmd_clr   = cmd_wr && (wdata_i[3:0] == CMD_CLEAR_FLAG);
  assign cmd_srst  = cmd_wr && (wdata_i[3:0] == CMD_SOFT_RESET);
  assign node_zero = wr_i && (addr_i == ADDR_NODE_ID) && (wdata_i == 8'h00);

  tsf_idle_timer u_idle (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .active_i  (line_receive_input),
    .expired_o (idle_pulse)
  );

  // ==================================================================
  // receive flag
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || cmd_srst) begin
      ri_reg    <= 1'b1; // R1
      rx_page_o <= 3'h0;
    end else if (rx_stored_i && !ri_reg) begin
      ri_reg <= 1'b1; // R1
    end else if (cmd_rx) begin
      ri_reg    <= 1'b0; // R2
      rx_page_o <= wdata_i[PAGE_LSB +: 3];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rx_nak_o <= 1'b0;
    end else begin
      rx_nak_o <= rx_request_i && ri_reg; // R3
    end
  end

  // ==================================================================
  // power-on and idle flags; set beats clear
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || cmd_srst || node_zero) begin
      por_reg <= 1'b1; // R6
    end else if (cmd_clr) begin
      por_reg <= 1'b0; // R7
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || cmd_srst) begin
      idle_reg <= 1'b0;
    end else if (idle_pulse) begin
      idle_reg <= 1'b1; // R9
    end else if (cmd_clr) begin
      idle_reg <= 1'b0; // R10
    end
  end

  // ==================================================================
  // transmit flags
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || cmd_srst) begin
      free_reg       <= 1'b1;
      tx_pending_reg <= 1'b0;
      tx_start_o     <= 1'b0;
      tx_page_o      <= 3'h0;
    end else begin
      tx_start_o <= 1'b0;
      if (cmd_dis || tx_done_i) begin
        free_reg       <= 1'b1; // R16
        tx_pending_reg <= 1'b0;
      end else if (cmd_tx) begin
        tx_pending_reg <= 1'b1;
        tx_page_o      <= wdata_i[PAGE_LSB +: 3];
      end else if (tx_pending_reg && token_i && free_reg) begin
        // stays available until the token actually arrives
        free_reg   <= 1'b0; // R17
        tx_start_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || cmd_srst) begin
      ack_reg <= 1'b0;
    end else if (tx_ack_i && !tx_broadcast_i && !free_reg) begin
      ack_reg <= 1'b1; // R12 R13
    end else if (cmd_tx) begin
      ack_reg <= 1'b0; // R15
    end
  end

  // ==================================================================
  // mask, read port, interrupt
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mask_reg <= MASK_RESET;
    end else if (wr_i && addr_i == ADDR_MASK) begin
      mask_reg <= wdata_i & IRQ_BITS;
    end
  end

  // bits six and five read zero; test bit zero
  always_comb begin
    status           = 8'h00; // R5 R8
    status[BIT_RI]   = ri_reg;
    status[BIT_POR]  = por_reg;
    status[BIT_IDLE] = idle_reg;
    status[BIT_ACK]  = ack_reg;
    status[BIT_FREE] = free_reg;
  end

  always_comb begin
    case (addr_i)
      ADDR_STATUS: rdata_next = status; // R18
      ADDR_MASK:   rdata_next = mask_reg;
      ADDR_IRQ:    rdata_next = {7'h00, irq_o};
      default:     rdata_next = 8'h00;
    endcase
  end

  // reads have no side effect on any flag
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rdata_next : 8'h00; // R19
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_o        <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      irq_o        <= |(status & mask_reg & IRQ_BITS); // R4
      soft_reset_o <= cmd_srst;
    end
  end

  // ==================================================================
  // checks
  sequence clr_cmd_s;
    cmd_clr && !idle_pulse && !cmd_srst;
  endsequence

  nak_when_inhib_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    rx_request_i && ri_reg |=> rx_nak_o) else $error("missing nak"); // R3
  rx_arm_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cmd_rx && !cmd_srst && !(rx_stored_i && !ri_reg) |=> !ri_reg)
    else $error("ri not cleared"); // R2
  rx_store_set_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    rx_stored_i && !ri_reg |=> ri_reg) else $error("ri not set"); // R1
  irq_level_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    |(status & mask_reg) |=> irq_o) else $error("irq missing"); // R4
  por_set_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    node_zero |=> por_reg) else $error("por not set"); // R6
  por_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !cmd_clr && por_reg |=> por_reg) else $error("por dropped"); // R7
  idle_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    clr_cmd_s |=> !idle_reg) else $error("idle not cleared"); // R10
  idle_set_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    idle_pulse |=> idle_reg) else $error("idle not set"); // R9
  bcast_ack_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !ack_reg && tx_broadcast_i |=> !ack_reg) else $error("bcast acked"); // R13
  free_set_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cmd_dis |=> free_reg) else $error("tx_free not set"); // R16
  free_token_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $fell(free_reg) |-> $past(token_i)) else $error("free cleared early"); // R17
  status_bits_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    status[6:3] == {2'b00, por_reg, 1'b0}) else $error("bad fixed bits"); // R8
endmodule

// [testbench/tsf_net_model.sv]
// Purpose: network line stand-in feeding events to the flag bank
// Assumes: bench requests are one-cycle pulses on ev_i
// Notes:   line sits at its pull-down level while quiet_i is high
module tsf_net_model (
  input  wire logic       clock_i,  // system clock
  input  wire logic       quiet_i,  // hold the line silent
  input  wire logic [4:0] ev_i,     // stored, offer, ack, done, token
  input  wire logic       bcast_i,  // packet is broadcast
  output logic            line_o,   // line activity
  output logic      [4:0] ev_o,     // registered events
  output logic            bcast_o   // registered broadcast level
);
  logic [1:0] beat_reg = 2'h0;
  // ==================================================================
  // a pulse every fourth cycle keeps the idle watchdog from firing
  always_ff @(posedge clock_i) begin
    beat_reg <= beat_reg + 2'h1;
    line_o   <= !quiet_i && (beat_reg == 2'h0);
  end
  // events arrive one cycle after the bench asks, as off a real wire
  always_ff @(posedge clock_i) begin
    ev_o    <= ev_i;
    bcast_o <= bcast_i;
  end
endmodule

// [testbench/tsf_status_flags_tb.sv]
// Purpose: self-checking bench of the status flag bank
// Assumes: register port answers reads one cycle later
// Notes:   idle watchdog runs at full length, about 5125 cycles
module tsf_status_flags_tb
  import tsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i, rst_b_i, wr_i, rd_i, quiet, bq, bc, line;
  logic       rx_nak_o, tx_start_o, soft_reset_o, irq_o;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d, m;
  logic [4:0] evq, ev;
  logic [2:0] tx_page_o, rx_page_o, pg;
  int         fail_count = 0;
  int         checks_done = 0;
  tsf_net_model i_tsf_net_model (.clock_i(clock_i), .quiet_i(quiet), .ev_i(evq),
    .bcast_i(bq), .line_o(line), .ev_o(ev), .bcast_o(bc));
  tsf_status_flags i_tsf_status_flags (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .line_receive_input(line), .rx_stored_i(ev[0]), .rx_request_i(ev[1]),
    .rx_nak_o(rx_nak_o), .tx_ack_i(ev[2]), .tx_broadcast_i(bc), .tx_done_i(ev[3]),
    .token_i(ev[4]), .tx_start_o(tx_start_o), .tx_page_o(tx_page_o),
    .rx_page_o(rx_page_o), .soft_reset_o(soft_reset_o), .irq_o(irq_o));
  // ==================================================================
  // helpers
  function automatic logic [7:0] st(logic ri, por, idle, ack, free);
    return {ri, 2'h0, por, 1'h0, idle, ack, free};
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask
  task automatic sr(logic [3:0] a, logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  // leaves the caller just after the clock edge on which the design sees the event
  task automatic pulse(int i);
    @(posedge clock_i);
    evq <= 5'(1 << i);
    @(posedge clock_i);
    evq <= 5'h00;
    @(posedge clock_i);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==================================================================
  // clock, watchdog, main sequence
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    #100us;
    fail_count++;
    print_verdict();
  end
  initial begin
    {rst_b_i, wr_i, rd_i, quiet, bq, addr_i, wdata_i, evq} = '0;
    void'($urandom(15022));
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    sr(ADDR_STATUS, st(1, 1, 0, 0, 1));
    sr(ADDR_STATUS, st(1, 1, 0, 0, 1));
    sr(ADDR_MASK, MASK_RESET);
    sr(4'h9, 8'h00);
    wr(ADDR_COMMAND, 8'h0e);
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    wr(ADDR_NODE_ID, 8'($urandom_range(1, 255)));
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    wr(ADDR_NODE_ID, 8'h00);
    sr(ADDR_STATUS, st(1, 1, 0, 0, 1));
    wr(ADDR_COMMAND, 8'h0e);
    pulse(1);
    chk(8'(rx_nak_o), 8'h01);
    pg = 3'($urandom);
    wr(ADDR_COMMAND, {1'b0, pg, CMD_ENABLE_RX});
    sr(ADDR_STATUS, st(0, 0, 0, 0, 1));
    chk(8'(rx_page_o), 8'(pg));
    pulse(1);
    chk(8'(rx_nak_o), 8'h00);
    pulse(0);
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    pulse(1);
    chk(8'(rx_nak_o), 8'h01);
    wr(ADDR_COMMAND, {1'b0, pg, CMD_ENABLE_TX});
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    pulse(4);
    chk({tx_start_o, 4'h0, tx_page_o}, {1'b1, 4'h0, pg});
    sr(ADDR_STATUS, st(1, 0, 0, 0, 0));
    pulse(2);
    pulse(3);
    sr(ADDR_STATUS, st(1, 0, 0, 1, 1));
    wr(ADDR_COMMAND, {4'h0, CMD_ENABLE_TX});
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    bq <= 1'b1;
    pulse(4);
    pulse(2);
    sr(ADDR_STATUS, st(1, 0, 0, 0, 0));
    wr(ADDR_COMMAND, {4'h0, CMD_DISABLE_TX});
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    bq <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      m = (k == 0) ? 8'h7a : 8'($urandom);
      wr(ADDR_MASK, m);
      repeat (2) @(posedge clock_i);
      #1;
      chk(8'(irq_o), 8'(|(m & 8'h81 & IRQ_BITS)));
    end
    wr(ADDR_MASK, 8'h04);
    quiet <= 1'b1;
    repeat (5000) @(posedge clock_i);
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    repeat (200) @(posedge clock_i);
    sr(ADDR_STATUS, st(1, 0, 1, 0, 1));
    chk(8'(irq_o), 8'h01);
    wr(ADDR_COMMAND, 8'h0e);
    quiet <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk(8'(irq_o), 8'h00);
    sr(ADDR_STATUS, st(1, 0, 0, 0, 1));
    wr(ADDR_COMMAND, {4'h0, CMD_SOFT_RESET});
    #1;
    chk(8'(soft_reset_o), 8'h01);
    repeat (3) @(posedge clock_i);
    sr(ADDR_STATUS, st(1, 1, 0, 0, 1));
    sr(ADDR_MASK, 8'h04);
    print_verdict();
  end
endmodule
